// ### logic/smeb_pkg.sv
package smeb_pkg;

   // ------------------------------------------------------------
   // geometry
   // ------------------------------------------------------------
   localparam int          NUM_CS    = 4;
   localparam int          CS_W      = 2;
   localparam int          DIV_W     = 8;
   localparam int          BITS_W    = 4;
   localparam int          WORD_W    = 16;
   localparam int          CNT_W     = 6;
   localparam int          TDR_W     = 25;

   // ------------------------------------------------------------
   // transmit word layout
   // ------------------------------------------------------------
   localparam int          DATA_LSB  = 0;
   localparam int          PCS_LSB   = 16;
   localparam int          FINAL_BIT = 24;

   // ------------------------------------------------------------
   // codes and reset values
   // ------------------------------------------------------------
   localparam logic [BITS_W-1:0] BITS_8      = 4'h0;
   localparam logic [4:0]        BASE_WIDTH  = 5'h08;
   localparam logic [DIV_W-1:0]  DIV_ONE     = 8'h01;
   localparam logic [NUM_CS-1:0] CS_N_IDLE   = 4'hF;
   localparam logic              SCLK_RESET  = 1'b0;
   localparam logic [1:0]        EXTRA_HALVES = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_LEAD  = 3'b001,
      ST_SHIFT = 3'b010,
      ST_EXTRA = 3'b011,
      ST_TRAIL = 3'b100
   } smeb_state_e;

   function automatic logic [4:0] smeb_width(input logic [BITS_W-1:0] code);
      smeb_width = 5'(BASE_WIDTH + {1'b0, code});
   endfunction : smeb_width

   function automatic logic smeb_div_is_one(input logic [DIV_W-1:0] div);
      smeb_div_is_one = (div <= DIV_ONE);
   endfunction : smeb_div_is_one

endpackage : smeb_pkg

// ### logic/smeb_tick.sv
module smeb_tick
(
   input  wire logic                        clk,
   input  wire logic                        reset,
   input  wire logic                        run,
   input  wire logic [smeb_pkg::DIV_W-1:0]  div,
   output logic                             tick
);

   logic [smeb_pkg::DIV_W-1:0] count;

   // ------------------------------------------------------------
   // half period counter; divider zero behaves as one
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         count <= '0;
      end
      else if (!run || tick)
      begin
         count <= '0;
      end
      else
      begin
         count <= count + 8'h01;
      end
   end

   assign tick = run && (smeb_pkg::smeb_div_is_one(div) || (count == div - 8'h01));

endmodule : smeb_tick

// ### logic/smeb_core.sv
module smeb_core
(
   input  wire logic                                               clk,
   input  wire logic                                               reset,
   input  wire logic [smeb_pkg::NUM_CS-1:0][smeb_pkg::DIV_W-1:0]   serial_clock_divider,
   input  wire logic [smeb_pkg::NUM_CS-1:0][smeb_pkg::BITS_W-1:0]  word_bits,
   input  wire logic [smeb_pkg::NUM_CS-1:0]                        idle_clock_level,
   input  wire logic [smeb_pkg::NUM_CS-1:0]                        capture_phase_select,
   input  wire logic [smeb_pkg::NUM_CS-1:0]                        cs_hold_after_transfer,
   input  wire logic                                               fixed_mode,
   input  wire logic [smeb_pkg::CS_W-1:0]                          fixed_cs,
   input  wire logic                                               soft_reset_cmd,
   input  wire logic                                               tx_write,
   input  wire logic [smeb_pkg::TDR_W-1:0]                         transmit_data_reg,
   input  wire logic                                               serial_data_in,
   output logic                                                    transmit_ready_flag,
   output logic                                                    transmit_idle_flag,
   output logic                                                    serial_clock_pin,
   output logic                                                    serial_data_out,
   output logic [smeb_pkg::NUM_CS-1:0]                             chip_select_n,
   output logic [smeb_pkg::WORD_W-1:0]                             rx_data,
   output logic                                                    rx_valid,
   output logic                                                    dma_halfword
);

   smeb_pkg::smeb_state_e state;
   logic [smeb_pkg::WORD_W-1:0] hold_data;
   logic [smeb_pkg::CS_W-1:0]   hold_cs;
   logic                        hold_final;
   logic                        hold_full;
   logic [smeb_pkg::WORD_W-1:0] word;
   logic [smeb_pkg::WORD_W-1:0] shreg;
   logic [smeb_pkg::WORD_W-1:0] rxreg;
   logic [smeb_pkg::CS_W-1:0]   cur_cs;
   logic [smeb_pkg::DIV_W-1:0]  cur_div;
   logic [smeb_pkg::DIV_W-1:0]  last_div;
   logic                        last_valid;
   logic [smeb_pkg::CS_W-1:0]   last_cs;
   logic [4:0]                  width;
   logic                        cur_idle_clock_level;
   logic                        cur_capture_phase_select;
   logic                        cur_hold;
   logic                        cur_final;
   logic                        extra;
   logic                        dup_arm;
   logic                        had_idle;
   logic                        half_reset;
   logic [smeb_pkg::CNT_W-1:0]  half_cnt;
   logic [1:0]                  extra_cnt;
   logic                        tick;
   logic                        start;
   logic                        ready_event;
   logic                        reset_ok;
   logic                        last_half;
   logic                        leading;
   logic                        do_sample;
   logic                        do_shift;
   logic [smeb_pkg::CS_W-1:0]   next_cs;
   logic [smeb_pkg::DIV_W-1:0]  next_div;
   logic [4:0]                  next_width;
   logic                        next_extra;
   logic                        next_dup;

   // ------------------------------------------------------------
   // start decode
   // ------------------------------------------------------------
   assign start       = (state == smeb_pkg::ST_IDLE) && hold_full;
   assign ready_event = start;
   assign reset_ok    = soft_reset_cmd && !ready_event;
   assign next_cs     = fixed_mode ? fixed_cs : hold_cs;
   assign next_div    = serial_clock_divider[next_cs];
   assign next_width  = smeb_pkg::smeb_width(word_bits[next_cs]);
   assign next_extra  = (idle_clock_level[next_cs] && !capture_phase_select[next_cs]
                         && ((next_div[0] && !smeb_pkg::smeb_div_is_one(next_div))
                             || (smeb_pkg::smeb_div_is_one(next_div) && last_valid
                                 && !smeb_pkg::smeb_div_is_one(last_div))))
                        || (smeb_pkg::smeb_div_is_one(next_div) && next_width[0]);
   assign next_dup    = cs_hold_after_transfer[next_cs] && smeb_pkg::smeb_div_is_one(next_div)
                        && last_valid && (last_cs == next_cs) && had_idle;
   assign last_half   = (half_cnt == smeb_pkg::CNT_W'({width, 1'b0} - 6'h01));
   assign leading     = !half_cnt[0];
   assign do_sample   = cur_capture_phase_select ? leading : !leading;
   assign do_shift    = cur_capture_phase_select ? !leading : (leading && (half_cnt != '0));

   assign transmit_ready_flag = !hold_full;
   assign transmit_idle_flag  = !hold_full && (state == smeb_pkg::ST_IDLE);

   smeb_tick u_tick
   (
      .clk   (clk),
      .reset (reset),
      .run   (state != smeb_pkg::ST_IDLE),
      .div   (cur_div),
      .tick  (tick)
   );

   // ------------------------------------------------------------
   // holding register
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         hold_full  <= 1'b0;
         hold_data  <= '0;
         hold_cs    <= '0;
         hold_final <= 1'b0;
      end
      else if (reset_ok)
      begin
         hold_full <= 1'b0;
      end
      else if (tx_write && !hold_full)
      begin
         hold_full  <= 1'b1;
         hold_data  <= transmit_data_reg[smeb_pkg::DATA_LSB +: smeb_pkg::WORD_W];
         hold_cs    <= transmit_data_reg[smeb_pkg::PCS_LSB +: smeb_pkg::CS_W];
         hold_final <= transmit_data_reg[smeb_pkg::FINAL_BIT];
      end
      else if (start)
      begin
         hold_full <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         state     <= smeb_pkg::ST_IDLE;
         half_cnt  <= '0;
         extra_cnt <= '0;
      end
      else if (reset_ok)
      begin
         state <= smeb_pkg::ST_IDLE;
      end
      else
      begin
         case (state)
            smeb_pkg::ST_IDLE:
            begin
               if (start)
               begin
                  state <= smeb_pkg::ST_LEAD;
               end
            end
            smeb_pkg::ST_LEAD:
            begin
               if (tick)
               begin
                  state    <= smeb_pkg::ST_SHIFT;
                  half_cnt <= '0;
               end
            end
            smeb_pkg::ST_SHIFT:
            begin
               if (tick)
               begin
                  half_cnt <= half_cnt + 6'h01;
                  if (last_half)
                  begin
                     state     <= extra ? smeb_pkg::ST_EXTRA : smeb_pkg::ST_TRAIL;
                     extra_cnt <= '0;
                  end
               end
            end
            smeb_pkg::ST_EXTRA:
            begin
               if (tick)
               begin
                  extra_cnt <= extra_cnt + 2'h1;
                  if (extra_cnt == smeb_pkg::EXTRA_HALVES - 2'h1)
                  begin
                     state <= smeb_pkg::ST_TRAIL;
                  end
               end
            end
            smeb_pkg::ST_TRAIL:
            begin
               if (tick)
               begin
                  state <= dup_arm ? smeb_pkg::ST_LEAD : smeb_pkg::ST_IDLE;
               end
            end
            default:
            begin
               state <= smeb_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // transfer setup latched at start
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         cur_cs    <= '0;
         cur_div   <= smeb_pkg::DIV_ONE;
         width     <= smeb_pkg::BASE_WIDTH;
         cur_idle_clock_level  <= 1'b0;
         cur_capture_phase_select <= 1'b0;
         cur_hold  <= 1'b0;
         cur_final <= 1'b0;
         word      <= '0;
         extra     <= 1'b0;
         dup_arm   <= 1'b0;
      end
      else if (start && !reset_ok)
      begin
         cur_cs    <= next_cs;
         cur_div   <= next_div;
         width     <= next_width;
         cur_idle_clock_level  <= idle_clock_level[next_cs];
         cur_capture_phase_select <= capture_phase_select[next_cs];
         cur_hold  <= cs_hold_after_transfer[next_cs];
         cur_final <= hold_final;
         word      <= hold_data;
         extra     <= next_extra;
         dup_arm   <= next_dup;
      end
      else if (state == smeb_pkg::ST_TRAIL && tick)
      begin
         dup_arm <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // history for the divider and same-slave effects
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         last_valid <= 1'b0;
         last_div   <= smeb_pkg::DIV_ONE;
         last_cs    <= '0;
         had_idle   <= 1'b0;
      end
      else if (start)
      begin
         last_valid <= 1'b1;
         last_div   <= next_div;
         last_cs    <= next_cs;
         had_idle   <= 1'b0;
      end
      else if (state == smeb_pkg::ST_IDLE)
      begin
         had_idle <= last_valid;
      end
   end

   // ------------------------------------------------------------
   // soft reset: a lone command leaves the cs/clock order broken
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         half_reset <= 1'b0;
      end
      else if (reset_ok)
      begin
         half_reset <= !half_reset;
      end
   end

   // ------------------------------------------------------------
   // shifter, capture and serial pins
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         shreg            <= '0;
         rxreg            <= '0;
         rx_data          <= '0;
         rx_valid         <= 1'b0;
         serial_data_out  <= 1'b0;
         serial_clock_pin <= smeb_pkg::SCLK_RESET;
      end
      else
      begin
         rx_valid <= 1'b0;
         if (state == smeb_pkg::ST_LEAD)
         begin
            // reload from the latched word so a repeated word goes out unchanged
            shreg            <= word;
            rxreg            <= '0;
            serial_data_out  <= word[4'(width - 5'h01)];
            serial_clock_pin <= cur_idle_clock_level;
         end
         else if ((state == smeb_pkg::ST_SHIFT || state == smeb_pkg::ST_EXTRA) && tick)
         begin
            serial_clock_pin <= !serial_clock_pin;
            if (state == smeb_pkg::ST_SHIFT)
            begin
               if (do_sample)
               begin
                  rxreg <= {rxreg[smeb_pkg::WORD_W-2:0], serial_data_in};
               end
               if (do_shift)
               begin
                  shreg           <= {shreg[smeb_pkg::WORD_W-2:0], 1'b0};
                  serial_data_out <= shreg[4'(width - 5'h02)];
               end
               if (last_half)
               begin
                  rx_valid <= 1'b1;
                  rx_data  <= do_sample ? {rxreg[smeb_pkg::WORD_W-2:0], serial_data_in} : rxreg;
               end
            end
         end
         else if (state == smeb_pkg::ST_IDLE && start)
         begin
            serial_clock_pin <= idle_clock_level[next_cs];
         end
      end
   end

   // ------------------------------------------------------------
   // chip selects
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         chip_select_n <= smeb_pkg::CS_N_IDLE;
      end
      else if (reset_ok)
      begin
         chip_select_n <= smeb_pkg::CS_N_IDLE;
      end
      else if (state == smeb_pkg::ST_LEAD && tick)
      begin
         chip_select_n <= ~(smeb_pkg::NUM_CS'(1) << cur_cs);
      end
      else if (state == smeb_pkg::ST_LEAD && !half_reset)
      begin
         chip_select_n <= ~(smeb_pkg::NUM_CS'(1) << cur_cs);
      end
      else if (state == smeb_pkg::ST_TRAIL && tick && !dup_arm && (!cur_hold || cur_final))
      begin
         chip_select_n <= smeb_pkg::CS_N_IDLE;
      end
   end

   // ------------------------------------------------------------
   // DMA transfer size always taken from chip select 0
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         dma_halfword <= 1'b0;
      end
      else
      begin
         dma_halfword <= (word_bits[0] != smeb_pkg::BITS_8);
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_size_cs0;
      @(posedge clk) disable iff (reset) ##1 dma_halfword == ($past(word_bits[0]) != smeb_pkg::BITS_8);
   endproperty
   a_size_cs0: assert property (p_size_cs0) else $error("transfer size not from cs0");

   property p_reset_collision;
      @(posedge clk) disable iff (reset) soft_reset_cmd && start |=> state == smeb_pkg::ST_LEAD;
   endproperty
   a_reset_collision: assert property (p_reset_collision) else $error("colliding soft reset acted");

   property p_odd_div_pulse;
      @(posedge clk) disable iff (reset)
         start && !reset_ok && idle_clock_level[next_cs] && !capture_phase_select[next_cs]
         && next_div[0] && next_div > 8'h01 |=> extra;
   endproperty
   a_odd_div_pulse: assert property (p_odd_div_pulse) else $error("odd divider pulse missing");

   property p_div1_odd_bits;
      @(posedge clk) disable iff (reset)
         start && !reset_ok && next_div == 8'h01
         && !(idle_clock_level[next_cs] && !capture_phase_select[next_cs] && last_valid && last_div > 8'h01)
         |=> extra == width[0];
   endproperty
   a_div1_odd_bits: assert property (p_div1_odd_bits) else $error("divider one pulse wrong");

   property p_all_div1;
      @(posedge clk) disable iff (reset)
         start && !reset_ok && next_div == 8'h01 && last_div == 8'h01 && !next_width[0] |=> !extra;
   endproperty
   a_all_div1: assert property (p_all_div1) else $error("spurious pulse at uniform divider");

   property p_dup;
      @(posedge clk) disable iff (reset) start && !reset_ok && next_dup |=> dup_arm;
   endproperty
   a_dup: assert property (p_dup) else $error("repeat not armed");

   property p_final_release;
      @(posedge clk) disable iff (reset)
         state == smeb_pkg::ST_TRAIL && tick && !dup_arm && cur_final && !reset_ok
         |=> chip_select_n == smeb_pkg::CS_N_IDLE && state == smeb_pkg::ST_IDLE;
   endproperty
   a_final_release: assert property (p_final_release) else $error("cs held after final word");

   property p_half_reset;
      @(posedge clk) disable iff (reset)
         state == smeb_pkg::ST_LEAD && !tick && half_reset && !reset_ok |=> $stable(chip_select_n);
   endproperty
   a_half_reset: assert property (p_half_reset) else $error("soft reset count wrong");

   property p_idle_level;
      @(posedge clk) disable iff (reset)
         state == smeb_pkg::ST_TRAIL && tick && !dup_arm && !reset_ok |=> serial_clock_pin == cur_idle_clock_level;
   endproperty
   a_idle_level: assert property (p_idle_level) else $error("clock not at idle level");

endmodule : smeb_core

// ### sim/smeb_slave_model.sv
module smeb_slave_model
(
   input  wire logic        sel_n,
   input  wire logic        sclk,
   input  wire logic        mosi,
   input  wire logic        idle_lvl,
   input  wire logic        lead_cap,
   input  wire logic [4:0]  width,
   input  wire logic [15:0] miso_word,
   output logic             miso,
   output logic [15:0]      got
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] sh;
   initial
   begin
      miso = 1'b0;
      got  = 16'h0000;
      sh   = 16'h0000;
   end
   // released line has no pull: show the inverse, never a stale copy
   always @(posedge sel_n)
      miso = ~miso;
   always @(negedge sel_n)
   begin
      sh   = miso_word << (5'h10 - width);
      got  = 16'h0000;
      miso = sh[15];
   end
   // only leading-edge capture is exact; the edges that do not capture move the next bit out
   always @(sclk)
   begin
      if (sel_n == 1'b0 && (sclk != idle_lvl) == lead_cap)
         got = {got[14:0], mosi};
      else if (sel_n == 1'b0)
      begin
         sh   = sh << 1;
         miso = sh[15];
      end
   end
endmodule : smeb_slave_model

// ### sim/test_spi_master_errata_behaviour.sv
module test_spi_master_errata_behaviour;
   timeunit 1ns;
   timeprecision 1ps;
   logic                clk;
   logic                reset;
   logic [3:0][7:0]     serial_clock_divider;
   logic [3:0][3:0]     word_bits;
   logic [3:0]          idle_clock_level;
   logic [3:0]          capture_phase_select;
   logic [3:0]          cs_hold_after_transfer;
   logic                fixed_mode;
   logic [1:0]          fixed_cs;
   logic                soft_reset_cmd;
   logic                tx_write;
   logic [24:0]         transmit_data_reg;
   logic                serial_data_in;
   logic                transmit_ready_flag;
   logic                transmit_idle_flag;
   logic                serial_clock_pin;
   logic                serial_data_out;
   logic [3:0]          chip_select_n;
   logic [15:0]         rx_data;
   logic                rx_valid;
   logic                dma_halfword;
   logic [15:0]         miso_word;
   logic [15:0]         got;
   logic [4:0]          cur_w;
   logic                cur_idle;
   logic                cur_phase;
   logic                last_sclk;
   logic [3:0]          last_cs;
   logic [31:0]         seed;
   logic [16:0]         exp_q[$];
   logic [16:0]         note;
   int                  miscompares;
   int                  num_checks;
   int                  changes;
   int                  prev_div;
   int                  dup_n;
   smeb_core smeb_core_inst (.clk, .reset, .serial_clock_divider, .word_bits, .idle_clock_level,
      .capture_phase_select, .cs_hold_after_transfer, .fixed_mode, .fixed_cs, .soft_reset_cmd, .tx_write,
      .transmit_data_reg, .serial_data_in, .transmit_ready_flag, .transmit_idle_flag, .serial_clock_pin,
      .serial_data_out, .chip_select_n, .rx_data, .rx_valid, .dma_halfword);
   smeb_slave_model smeb_slave_model_inst (.sel_n(&chip_select_n), .sclk(serial_clock_pin),
      .mosi(serial_data_out), .idle_lvl(cur_idle), .lead_cap(cur_phase), .width(cur_w), .miso_word,
      .miso(serial_data_in), .got);
   always #2 clk = ~clk;
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : next_rand
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      num_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic close_out;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   task automatic cfg(input int cs, input logic [7:0] d, input logic [3:0] b, input logic i, p, h);
      @(posedge clk);
      serial_clock_divider[cs]   <= d;
      word_bits[cs]              <= b;
      idle_clock_level[cs]       <= i;
      capture_phase_select[cs]   <= p;
      cs_hold_after_transfer[cs] <= h;
      @(negedge clk);
   endtask : cfg
   task automatic wait_idle;
      int n;
      @(negedge clk);
      for (n = 0; n < 5000 && transmit_idle_flag !== 1'b1; n++)
         @(negedge clk);
      if (n == 5000)
         chk("idle wait", 32'h1, 32'h0);
   endtask : wait_idle
   task automatic pulse_reset;
      @(posedge clk);
      soft_reset_cmd <= 1'b1;
      @(posedge clk);
      soft_reset_cmd <= 1'b0;
   endtask : pulse_reset
   // ------------------------------------------------------------
   // one word: counts serial clock edges, notes the received word
   // ------------------------------------------------------------
   task automatic send(input logic [1:0] cs, input logic fin, input logic collide, input logic chk_rx);
      int          d;
      int          w;
      int          ex;
      int          start;
      logic [15:0] m;
      logic [15:0] dat;
      logic        slow;
      d         = (serial_clock_divider[cs] == 8'h00) ? 1 : int'(serial_clock_divider[cs]);
      w         = 8 + int'(word_bits[cs]);
      m         = 16'((32'h1 << w) - 1);
      slow      = idle_clock_level[cs] && !capture_phase_select[cs];
      ex        = int'((slow && d > 1 && d % 2 == 1) || (d == 1 && w % 2 == 1) || (slow && d == 1 && prev_div > 1));
      seed      = next_rand(seed);
      dat       = seed[15:0];
      miso_word = seed[31:16];
      cur_w     = 5'(w);
      cur_idle  = idle_clock_level[cs];
      cur_phase = capture_phase_select[cs];
      wait_idle();
      @(posedge clk);
      tx_write          <= 1'b1;
      transmit_data_reg <= {fin, 6'h00, cs, dat};
      exp_q.push_back({chk_rx, miso_word & m});
      if (dup_n != 0)
         exp_q.push_back({1'b0, 16'h0000});
      @(posedge clk);
      tx_write       <= 1'b0;
      soft_reset_cmd <= collide;
      start = changes;
      @(negedge clk);
      chk("ready low", 32'h0, {31'h0, transmit_ready_flag});
      @(posedge clk);
      soft_reset_cmd <= 1'b0;
      wait_idle();
      repeat (4) @(negedge clk);
      chk("sclk edges", 32'(2 * (w + ex) * (1 + dup_n)), 32'(changes - start));
      if (chk_rx && capture_phase_select[cs] && ex == 0)
         chk("mosi word", {16'h0000, dat & m}, {16'h0000, got & m});
      prev_div = d;
   endtask : send
   always @(negedge clk)
   begin
      if (serial_clock_pin !== last_sclk && (chip_select_n !== 4'hF || last_cs !== 4'hF))
         changes++;
      last_sclk = serial_clock_pin;
      last_cs   = chip_select_n;
   end
   always @(negedge clk)
   begin
      if (rx_valid === 1'b1 && exp_q.size() > 0)
      begin
         note = exp_q.pop_front();
         if (note[16])
            chk("rx word", {16'h0000, note[15:0]}, {16'h0000, rx_data});
      end
      else if (rx_valid === 1'b1)
         chk("spare rx", 32'h0, 32'h1);
   end
   initial
   begin
      #200000;
      miscompares++;
      close_out();
   end
   initial
   begin
      clk = 1'b0;
      reset = 1'b1;
      serial_clock_divider = {4{8'h02}};
      word_bits = 16'h0000;
      idle_clock_level = 4'h0;
      capture_phase_select = 4'hF;
      cs_hold_after_transfer = 4'h0;
      fixed_mode = 1'b0;
      fixed_cs = 2'h0;
      soft_reset_cmd = 1'b0;
      tx_write = 1'b0;
      transmit_data_reg = 25'h0000000;
      miso_word = 16'h0000;
      cur_w = 5'h08;
      cur_idle = 1'b0;
      cur_phase = 1'b1;
      seed = 32'h5B0B;
      prev_div = 1;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      for (int c = 0; c <= 8; c++)
      begin
         cfg(1, 8'h01, 4'(c), 1'b0, 1'b1, 1'b0);
         send(2'h1, 1'b0, 1'b0, 1'b1);
      end
      $display("test width table done");
      // idle high with phase zero is set on purpose here
      for (int d = 2; d <= 5; d++)
      begin
         cfg(0, 8'(d), 4'h0, 1'b1, 1'b0, 1'b0);
         send(2'h0, 1'b0, 1'b0, 1'b0);
      end
      cfg(0, 8'h02, 4'h0, 1'b1, 1'b0, 1'b0);
      cfg(1, 8'h01, 4'h0, 1'b1, 1'b0, 1'b0);
      send(2'h0, 1'b0, 1'b0, 1'b0);
      send(2'h1, 1'b0, 1'b0, 1'b0);
      cfg(0, 8'h01, 4'h0, 1'b1, 1'b0, 1'b0);
      send(2'h0, 1'b0, 1'b0, 1'b0);
      send(2'h1, 1'b0, 1'b0, 1'b0);
      $display("test divider mix done");
      cfg(2, 8'h02, 4'h0, 1'b0, 1'b1, 1'b0);
      send(2'h2, 1'b0, 1'b1, 1'b1);
      pulse_reset();
      send(2'h2, 1'b0, 1'b0, 1'b1);
      pulse_reset();
      wait_idle();
      chk("cs after reset", 32'hF, {28'h0, chip_select_n});
      send(2'h2, 1'b0, 1'b0, 1'b1);
      $display("test soft reset done");
      // hold with divider one on purpose: same slave again after a gap
      cfg(3, 8'h01, 4'h0, 1'b0, 1'b1, 1'b1);
      send(2'h3, 1'b0, 1'b0, 1'b0);
      dup_n = 1;
      send(2'h3, 1'b1, 1'b0, 1'b0);
      dup_n = 0;
      fixed_mode <= 1'b1;
      fixed_cs   <= 2'h2;
      // hold only with a divider above one; chip select not driven as a general output
      cfg(2, 8'h02, 4'h0, 1'b0, 1'b1, 1'b1);
      send(2'h2, 1'b0, 1'b0, 1'b0);
      chk("cs held", 32'hB, {28'h0, chip_select_n});
      send(2'h2, 1'b1, 1'b0, 1'b0);
      chk("cs final", 32'hF, {28'h0, chip_select_n});
      cfg(2, 8'h02, 4'h0, 1'b0, 1'b1, 1'b0);
      fixed_cs <= 2'h1;
      cfg(0, 8'h02, 4'h2, 1'b0, 1'b1, 1'b0);
      cfg(1, 8'h02, 4'h0, 1'b0, 1'b1, 1'b0);
      repeat (3) @(negedge clk);
      chk("dma size", 32'h1, {31'h0, dma_halfword});
      cfg(0, 8'h02, 4'h0, 1'b0, 1'b1, 1'b0);
      repeat (3) @(negedge clk);
      chk("dma size", 32'h0, {31'h0, dma_halfword});
      fixed_mode <= 1'b0;
      for (int k = 0; k < 12; k++)
      begin
         seed = next_rand(seed);
         cfg(int'(seed[1:0]), 8'(seed[3:2]) + 8'h01, 4'(seed[7:4] % 9), seed[8], seed[9], 1'b0);
         send(seed[1:0], 1'b0, 1'b0, seed[9]);
      end
      $display("test random words done");
      close_out();
   end
endmodule : test_spi_master_errata_behaviour
